// ---- hw/dlag_defs.svh ----
/*
 * Offsets, field positions, encodings and timing counts of the doubleword
 * load address generator. Definitions only; included by the package and the
 * design module.
 */
`ifndef DLAG_DEFS_SVH
`define DLAG_DEFS_SVH

// instruction word field positions
`define DLAG_CREG_HI 31
`define DLAG_CREG_LO 29
`define DLAG_DST_HI 27
`define DLAG_DST_LO 24
`define DLAG_DST_B0 23
`define DLAG_BASE_HI 22
`define DLAG_BASE_LO 18
`define DLAG_OFS_HI 17
`define DLAG_OFS_LO 13
`define DLAG_MODE_HI 12
`define DLAG_MODE_LO 9
`define DLAG_R_BIT 8
`define DLAG_Y_BIT 7
`define DLAG_LDST_HI 6
`define DLAG_LDST_LO 4
`define DLAG_TAIL_HI 3
`define DLAG_TAIL_LO 2
`define DLAG_S_BIT 1

// mode field bits
`define DLAG_MODE_MODIFY 3
`define DLAG_MODE_REGOFS 2
`define DLAG_MODE_POST 1
`define DLAG_MODE_ADD 0

// encodings
`define DLAG_LDST_ALIGNED 3'h6
`define DLAG_LDST_UNALIGNED 3'h2
`define DLAG_TAIL_ALIGNED 2'h2
`define DLAG_TAIL_UNALIGNED 2'h1
`define DLAG_DW_SHIFT 3

// circular addressing control: 2-bit mode per pointer, two block sizes
`define DLAG_CIRC_FIRST_REG 4
`define DLAG_AMR_B_BASE 8
`define DLAG_AMR_BK0_LO 16
`define DLAG_AMR_BK1_LO 21
`define DLAG_AMR_BK_W 5
`define DLAG_AMR_LINEAR 2'h0
`define DLAG_AMR_BK0 2'h1
`define DLAG_AMR_BK1 2'h2

// pipeline: destination pair is written in the fifth execute stage
`define DLAG_LOAD_STAGES 5

`endif

// ---- hw/dlag_pkg.sv ----
/*
 * Types of the doubleword load address generator.
 * Assumes dlag_defs.svh is on the include path.
 */
package dlag_pkg;
  `include "dlag_defs.svh"

  typedef enum logic [1:0] {
    DLAG_OP_NONE = 2'b00,
    DLAG_OP_ALIGNED = 2'b01,
    DLAG_OP_UNALIGNED = 2'b10
  } dlag_op_t;

  // base pointer update, written back in the first execute stage
  typedef struct packed {
    logic en;
    logic file_b;
    logic [4:0] idx;
    logic [31:0] val;
  } dlag_base_wb_t;

  // memory read request
  typedef struct packed {
    logic en;
    logic [31:0] addr;
  } dlag_mem_req_t;

  // destination pair write
  typedef struct packed {
    logic en;
    logic file_b;
    logic [4:0] idx_even;
    logic [31:0] even;
    logic [31:0] odd;
  } dlag_pair_wb_t;

  // state carried down the load pipeline
  typedef struct packed {
    logic en;
    logic file_b;
    logic [4:0] idx_even;
    logic big_endian;
  } dlag_pipe_t;
endpackage

// ---- hw/dlag_load_unit.sv ----
/*
 * Decodes and executes aligned and non-aligned doubleword loads: effective
 * address generation, base pointer update and destination pair write.
 * Assumes the register file reads base and offset from the instruction's
 * fields combinationally in the issue cycle, the condition is evaluated
 * outside, and memory returns data exactly two cycles after the request
 * appears (so it is present in the fourth execute stage).
 */
// Summary of operation
// RULE1 - aligned load fetches 64 bits, base plus offset
// RULE2 - side bit picks unit and base/offset file
// RULE3 - destination file bit picks A or B
// RULE4 - aligned load recognised by marker bit one
// RULE5 - aligned encoding: access type 110, even destination
// RULE6 - aligned offset always shifted left by three
// RULE7 - post modes access unmodified base, others result
// RULE8 - mode field selects offset and update kind
// RULE9 - circular arithmetic for pointers four to seven
// RULE10 - low word even register, high word odd
// RULE11 - first memory word placement follows endian mode
// RULE12 - software keeps aligned addresses doubleword aligned
// RULE13 - base updated in E1, pair in E5
// RULE14 - non-aligned load accepts any byte address
// RULE15 - scale bit chooses shifted or byte offset
// RULE16 - non-aligned destination file independent of side
// RULE17 - software issues no parallel memory access
// RULE18 - non-aligned: data four slots, base zero slots
// RULE19 - failed condition makes the instruction a no-op
`timescale 1ns/1ps
`include "dlag_defs.svh"

module dlag_load_unit (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic issue_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic cond_pass_in,
  input wire logic [31:0] base_pointer_reg_in,
  input wire logic [31:0] offset_index_reg_in,
  input wire logic [31:0] address_mode_control_reg_in,
  input wire logic big_endian_in,
  input wire logic [63:0] mem_rdata_in,
  output dlag_pkg::dlag_mem_req_t mem_req_out,
  output dlag_pkg::dlag_base_wb_t base_wb_out,
  output dlag_pkg::dlag_pair_wb_t pair_wb_out,
  output logic address_unit_one_busy_out,
  output logic address_unit_two_busy_out
);
  import dlag_pkg::*;

  localparam int PIPE_DEPTH = `DLAG_LOAD_STAGES - 2;

  // instruction fields
  wire [3:0] mode = instr_in[`DLAG_MODE_HI:`DLAG_MODE_LO];
  wire [2:0] access_type_field = instr_in[`DLAG_LDST_HI:`DLAG_LDST_LO];
  wire [1:0] tail = instr_in[`DLAG_TAIL_HI:`DLAG_TAIL_LO];
  wire marker = instr_in[`DLAG_R_BIT];
  wire side_b = instr_in[`DLAG_Y_BIT];
  wire dst_file_b = instr_in[`DLAG_S_BIT];
  wire offset_scale_select = instr_in[`DLAG_DST_B0];
  wire [4:0] base_idx = instr_in[`DLAG_BASE_HI:`DLAG_BASE_LO];
  wire [4:0] short_offset_const = instr_in[`DLAG_OFS_HI:`DLAG_OFS_LO];
  wire [4:0] dst_even =
    {instr_in[`DLAG_DST_HI:`DLAG_DST_LO], 1'b0}; // [RULE10] [RULE5]

  // mode decode; modify clear with post set is not a defined code
  wire m_modify = mode[`DLAG_MODE_MODIFY]; // [RULE8]
  wire m_regofs = mode[`DLAG_MODE_REGOFS]; // [RULE8]
  wire m_post = mode[`DLAG_MODE_POST]; // [RULE8]
  wire m_add = mode[`DLAG_MODE_ADD]; // [RULE8]
  wire mode_ok = m_modify | ~m_post;

  // opcode recognition
  wire is_aligned = marker // [RULE4]
    & (access_type_field == `DLAG_LDST_ALIGNED) // [RULE5]
    & ~instr_in[`DLAG_DST_B0] // [RULE5]
    & (tail == `DLAG_TAIL_ALIGNED);
  wire is_unaligned = marker
    & (access_type_field == `DLAG_LDST_UNALIGNED)
    & (tail == `DLAG_TAIL_UNALIGNED);
  wire dlag_op_t load_doubleword_op = !mode_ok ? DLAG_OP_NONE :
    is_aligned ? DLAG_OP_ALIGNED :
    is_unaligned ? DLAG_OP_UNALIGNED : DLAG_OP_NONE;

  // failed condition suppresses read, update and write alike
  wire go = issue_valid_in & cond_pass_in
    & (load_doubleword_op != DLAG_OP_NONE); // [RULE19]

  // offset select and scaling
  wire [31:0] raw_ofs = m_regofs ? offset_index_reg_in
    : {27'h0, short_offset_const}; // [RULE1]
  wire do_scale = (load_doubleword_op == DLAG_OP_ALIGNED)
    | offset_scale_select; // [RULE6] [RULE15]
  wire [31:0] scaled_ofs = do_scale ? (raw_ofs << `DLAG_DW_SHIFT)
    : raw_ofs; // [RULE6] [RULE15]
  wire [31:0] lin_result = m_add ? base_pointer_reg_in + scaled_ofs
    : base_pointer_reg_in - scaled_ofs;

  // circular addressing: only pointers 4..7 of each file have a mode field
  wire circ_reg = (base_idx[4:2] == 3'(`DLAG_CIRC_FIRST_REG >> 2));
  wire [4:0] amr_pos = side_b ? 5'(`DLAG_AMR_B_BASE + 2 * base_idx[1:0])
    : 5'(2 * base_idx[1:0]); // [RULE2]
  wire [1:0] amr_mode = address_mode_control_reg_in[amr_pos +: 2];
  wire [4:0] bk0 = address_mode_control_reg_in[`DLAG_AMR_BK0_LO +:
    `DLAG_AMR_BK_W];
  wire [4:0] bk1 = address_mode_control_reg_in[`DLAG_AMR_BK1_LO +:
    `DLAG_AMR_BK_W];
  wire use_circ = circ_reg & ((amr_mode == `DLAG_AMR_BK0)
    | (amr_mode == `DLAG_AMR_BK1)); // [RULE9]
  wire [4:0] bk_sel = (amr_mode == `DLAG_AMR_BK1) ? bk1 : bk0;
  // block of 2^(N+1) bytes; 33-bit shift keeps N=31 from overflowing
  wire [32:0] blk_one = 33'h1 << (6'(bk_sel) + 6'h1);
  wire [31:0] blk_mask = 32'(blk_one - 33'h1);
  // wrap inside the block, keep the base's upper bits
  wire [31:0] result = use_circ
    ? ((base_pointer_reg_in & ~blk_mask) | (lin_result & blk_mask))
    : lin_result; // [RULE9]

  // post modes access the untouched base
  wire [31:0] eff_addr = (m_modify & m_post) ? base_pointer_reg_in
    : result; // [RULE7] [RULE14]

  // registered outputs and pipeline
  dlag_mem_req_t mem_req_ff;
  dlag_mem_req_t nxt_mem_req;
  dlag_base_wb_t base_wb_ff;
  dlag_base_wb_t nxt_base_wb;
  dlag_pair_wb_t pair_wb_ff;
  dlag_pair_wb_t nxt_pair_wb;
  dlag_pipe_t pipe_ff [1:PIPE_DEPTH];
  dlag_pipe_t nxt_pipe_head;
  logic unit_one_ff;
  logic unit_two_ff;

  assign nxt_mem_req = '{en: go, addr: eff_addr}; // [RULE1] [RULE14]

  // base updated at the end of E1, visible in the next cycle
  assign nxt_base_wb = '{en: go & m_modify, file_b: side_b, // [RULE13]
    idx: base_idx, val: result}; // [RULE2] [RULE18]

  assign nxt_pipe_head = '{en: go, file_b: dst_file_b, // [RULE3] [RULE16]
    idx_even: dst_even, big_endian: big_endian_in};

  // lower address word is first in memory
  wire [31:0] first_word = mem_rdata_in[31:0];
  wire [31:0] second_word = mem_rdata_in[63:32];
  wire dlag_pipe_t tail_st = pipe_ff[PIPE_DEPTH];
  assign nxt_pair_wb = '{en: tail_st.en, file_b: tail_st.file_b,
    idx_even: tail_st.idx_even,
    even: tail_st.big_endian ? second_word : first_word, // [RULE11]
    odd: tail_st.big_endian ? first_word : second_word}; // [RULE10]

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mem_req_ff <= '0;
      base_wb_ff <= '0;
      pair_wb_ff <= '0;
      unit_one_ff <= 1'b0;
      unit_two_ff <= 1'b0;
    end else begin
      mem_req_ff <= nxt_mem_req;
      base_wb_ff <= nxt_base_wb;
      pair_wb_ff <= nxt_pair_wb; // [RULE13] [RULE18]
      unit_one_ff <= go & ~side_b; // [RULE2]
      unit_two_ff <= go & side_b; // [RULE2]
    end
  end

  // four delay slots: E1 issue, data captured in E4, pair written in E5
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 1; i <= PIPE_DEPTH; i++) begin
        pipe_ff[i] <= '0;
      end
    end else begin
      pipe_ff[1] <= nxt_pipe_head; // [RULE13]
      for (int i = 2; i <= PIPE_DEPTH; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
      end
    end
  end

  assign mem_req_out = mem_req_ff;
  assign base_wb_out = base_wb_ff;
  assign pair_wb_out = pair_wb_ff;
  assign address_unit_one_busy_out = unit_one_ff;
  assign address_unit_two_busy_out = unit_two_ff;
endmodule

// ---- dv/dlag_load_unit_properties.sv ----
/* Port checker for dlag_load_unit.
   Assumes it is bound to every instance and sees only its ports. */
`timescale 1ns/1ps
module dlag_load_unit_properties (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic issue_valid_in,
  input wire logic cond_pass_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] base_pointer_reg_in,
  input wire logic big_endian_in,
  input wire logic [63:0] mem_rdata_in,
  input dlag_pkg::dlag_mem_req_t mem_req_out,
  input dlag_pkg::dlag_base_wb_t base_wb_out,
  input dlag_pkg::dlag_pair_wb_t pair_wb_out,
  input wire logic address_unit_one_busy_out,
  input wire logic address_unit_two_busy_out
);
  import dlag_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_cond; mem_req_out.en |-> $past(issue_valid_in & cond_pass_in);
  endproperty
  a_cond: assert property (p_cond)
    else $error("request without issue");
  property p_lat; mem_req_out.en |-> ##3 pair_wb_out.en; endproperty
  a_lat: assert property (p_lat) else $error("pair write late");
  property p_pair; pair_wb_out.en |-> $past(mem_req_out.en, 3); endproperty
  a_pair: assert property (p_pair) else $error("stray pair write");
  property p_base;
    base_wb_out.en |-> mem_req_out.en && $past(instr_in[12]);
  endproperty
  a_base: assert property (p_base) else $error("stray base update");
  property p_unit; mem_req_out.en |-> address_unit_two_busy_out ==
    $past(instr_in[7])
    && (address_unit_one_busy_out ^ address_unit_two_busy_out);
  endproperty
  a_unit: assert property (p_unit) else $error("wrong unit busy");
  property p_post; mem_req_out.en && $past(instr_in[10]) |->
    mem_req_out.addr == $past(base_pointer_reg_in); endproperty
  a_post: assert property (p_post) else $error("post address wrong");
  property p_le; pair_wb_out.en && !$past(big_endian_in, 4) |->
    {pair_wb_out.odd, pair_wb_out.even} == $past(mem_rdata_in); endproperty
  a_le: assert property (p_le) else $error("little endian order");
  property p_be; pair_wb_out.en && $past(big_endian_in, 4) |->
    {pair_wb_out.even, pair_wb_out.odd} == $past(mem_rdata_in); endproperty
  a_be: assert property (p_be) else $error("big endian order");
endmodule
bind dlag_load_unit dlag_load_unit_properties u_props (.*);

// ---- dv/dlag_mem_model.sv ----
/* Data memory seen by the load unit.
   Assumes requests are one-cycle pulses; data comes two cycles later. */
`timescale 1ns/1ps
module dlag_mem_model (
  input wire logic ref_clk_in,
  input dlag_pkg::dlag_mem_req_t mem_req_in,
  output logic [63:0] mem_rdata_out = 64'h0
);
  import dlag_pkg::*;
  localparam logic [31:0] K = 32'hc3c3_0000;
  logic hit_ff = 1'b0;
  logic [31:0] addr_ff;
  // any byte address served; idle data toggles so stale data never matches
  always @(posedge ref_clk_in) begin
    hit_ff <= mem_req_in.en;
    addr_ff <= mem_req_in.addr;
    mem_rdata_out <= hit_ff ? {(addr_ff + 32'h4) ^ K, addr_ff ^ K}
                            : ~mem_rdata_out;
  end
endmodule

// ---- dv/testbench.sv ----
/* Self-checking bench for dlag_load_unit.
   Assumes the memory model answers in the fourth execute stage. */
`timescale 1ns/1ps
module testbench;
  import dlag_pkg::*;
  localparam logic [31:0] K = 32'hc3c3_0000;
  localparam logic [3:0] MD [12] = '{4'h5, 4'h4, 4'hd, 4'hc, 4'hf, 4'he,
    4'h1, 4'h0, 4'h9, 4'h8, 4'hb, 4'ha};
  logic ref_clk_in = 0, sys_rst_in = 1, issue_valid_in = 0;
  logic cond_pass_in = 0, big_endian_in = 0;
  logic [31:0] instr_in = 0, base_pointer_reg_in = 0;
  logic [31:0] offset_index_reg_in = 0, address_mode_control_reg_in = 0;
  logic [63:0] mem_rdata_in;
  dlag_mem_req_t mem_req_out;
  dlag_base_wb_t base_wb_out;
  dlag_pair_wb_t pair_wb_out;
  logic address_unit_one_busy_out, address_unit_two_busy_out;
  int err_total = 0, n_compared = 0, cyc = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  dlag_load_unit u_dlag_load_unit (.*);
  dlag_mem_model u_dlag_mem_model (.ref_clk_in(ref_clk_in),
    .mem_req_in(mem_req_out), .mem_rdata_out(mem_rdata_in));
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      stop_test;
    end
  end
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  function logic [31:0] mk(logic al, logic [3:0] d, logic b23, logic [4:0] br,
      logic [4:0] of, logic [3:0] md, logic y, logic s);
    return {4'h0, d, b23, br, of, md, 1'b1, y, al ? 5'h1a : 5'h09, s, 1'b0};
  endfunction
  task ld(input logic [31:0] ins, b, o, address_mode_control_reg, input logic be, cp);
    logic [3:0] md;
    logic [31:0] of, lin, ea;
    logic ok;
    md = ins[12:9];
    ok = cp && ins[8] && !(!md[3] && md[1]) &&
      ((ins[6:2] == 5'h1a && !ins[23]) || ins[6:2] == 5'h09);
    of = md[2] ? o : {27'h0, ins[17:13]};
    if (ins[6:4] == 3'h6 || ins[23]) of = of << 3;
    lin = md[0] ? b + of : b - of;
    // circular case uses a 16-byte block only
    if (address_mode_control_reg != 0) lin = {b[31:4], lin[3:0]};
    ea = md[1] ? b : lin;
    @(posedge ref_clk_in);
    issue_valid_in <= 1;
    instr_in <= ins;
    base_pointer_reg_in <= b;
    offset_index_reg_in <= o;
    address_mode_control_reg_in <= address_mode_control_reg;
    big_endian_in <= be;
    cond_pass_in <= cp;
    @(posedge ref_clk_in);
    issue_valid_in <= 0;
    #1 chk("req_en", ok, mem_req_out.en);
    if (ok) chk("addr", ea, mem_req_out.addr);
    chk("base_en", ok && md[3], base_wb_out.en);
    if (ok && md[3]) chk("base", {ins[7], ins[22:18], lin},
      {base_wb_out.file_b, base_wb_out.idx, base_wb_out.val});
    chk("unit", {ok && ins[7], ok && !ins[7]},
      {address_unit_two_busy_out, address_unit_one_busy_out});
    repeat (3) @(posedge ref_clk_in);
    #1 chk("pair_en", ok, pair_wb_out.en);
    if (ok) chk("dest", {ins[1], ins[27:24], 1'b0},
      {pair_wb_out.file_b, pair_wb_out.idx_even});
    if (ok) chk("data", be ? {(ea + 32'h4) ^ K, ea ^ K}
      : {ea ^ K, (ea + 32'h4) ^ K}, {pair_wb_out.even, pair_wb_out.odd});
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 0;
    // aligned bases keep doubleword effective addresses, except the circular case with base 0x100c
    // one access at a time, nothing in parallel
    for (int i = 0; i < 12; i++)
      ld(mk(1, 4'(i), 0, 5'(i + 1), 5'd3, MD[i], i[0], i[1]),
        32'h2000_0100, 32'h9, 0, i[2], 1);
    ld(mk(0, 4'h6, 0, 5'd2, 5'd7, 4'hd, 0, 1), 32'h3001, 5, 0, 1, 1);
    ld(mk(0, 4'h3, 1, 5'd9, 5'd2, 4'h9, 1, 0), 32'h4003, 0, 0, 0, 1);
    ld(mk(1, 4'h2, 0, 5'd5, 5'd1, 4'h1, 0, 0), 32'h100c, 0,
      32'h0003_0004, 0, 1);
    ld(mk(1, 4'h2, 0, 5'd1, 5'd1, 4'hd, 0, 0), 32'h100, 0, 0, 0, 0);
    ld(mk(1, 4'h2, 0, 5'd1, 5'd1, 4'h2, 0, 0), 32'h100, 0, 0, 0, 1);
    ld(mk(1, 4'h2, 0, 5'd1, 5'd1, 4'hd, 0, 0) & ~32'h100, 32'h100,
      0, 0, 0, 1);
    ld(mk(1, 4'h2, 1, 5'd1, 5'd1, 4'hd, 0, 0), 32'h100, 0, 0, 0, 1);
    // in-flight load must be dropped by a mid-run reset
    @(posedge ref_clk_in);
    issue_valid_in <= 1;
    instr_in <= mk(1, 4'h1, 0, 5'd1, 5'd1, 4'h5, 0, 0);
    cond_pass_in <= 1;
    @(posedge ref_clk_in);
    issue_valid_in <= 0;
    sys_rst_in <= 1;
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 0;
    #1 chk("rst_pair", 1'b0, pair_wb_out.en);
    chk("rst_req", 1'b0, mem_req_out.en);
    ld(mk(1, 4'h4, 0, 5'd2, 5'd2, 4'h5, 1, 1), 32'h2000_0200, 0,
      0, 0, 1);
    stop_test;
  end
endmodule
